// ### bench/spg_assertions.sv
// Host port link checks for the port state gating block
`timescale 1ns/1ns
`default_nettype none
module spg_assertions
	import spg_pkg::*;
(
	input wire logic clk, // Core clock
	input wire logic rst_n, // Asynchronous reset
	input wire logic reg_req, // Register request
	input wire logic reg_we, // Write flag
	input wire logic [7:0] reg_addr, // Register address
	input wire logic [7:0] reg_wdata, // Write data
	input wire logic reg_ack, // Register answer
	input wire logic [7:0] reg_rdata, // Read data
	input wire logic th_valid, // To-host beat valid
	input wire logic th_ready, // To-host ready
	input wire logic [SPG_DW-1:0] th_data, // To-host data
	input wire logic th_last, // To-host last beat
	input wire logic [2:0] th_port, // Ingress port tag
	input wire logic fh_valid, // From-host beat valid
	input wire logic fh_ready, // From-host ready
	input wire logic [SPG_DW-1:0] fh_data, // From-host data
	input wire logic fh_last, // From-host last beat
	input wire logic [2:0] fh_port // Target port tag
);
	default clocking cb @(posedge clk); endclocking
	default disable iff (!rst_n);
	logic map_hit;
	assign map_hit = (reg_addr[3:0] == 4'h2) && (reg_addr[7:4] >= 4'h1) && (reg_addr[7:4] <= 4'h4);
	sequence s_req_open;
		reg_req && !reg_ack;
	endsequence
	sequence s_ack_close;
		reg_ack ##1 (!reg_ack && !reg_req);
	endsequence
	chk_ack_one_cycle: assert property (s_req_open |=> s_ack_close)
		else $error("register request not answered in one cycle");
	chk_req_steady: assert property (s_req_open |=> reg_req && $stable({reg_we, reg_addr, reg_wdata}))
		else $error("register request changed before answer");
	chk_ack_pulse: assert property (reg_ack |=> !reg_ack)
		else $error("register answer longer than one cycle");
	chk_write_echo: assert property (reg_ack && reg_we |-> reg_rdata == reg_wdata)
		else $error("write answer does not echo data");
	chk_unmapped_zero: assert property (reg_ack && !reg_we && !map_hit |-> reg_rdata == 8'h00)
		else $error("unmapped register read not zero");
	chk_th_steady: assert property (th_valid && !th_ready |=> th_valid && $stable({th_data, th_last, th_port}))
		else $error("to-host beat changed while stalled");
	chk_fh_steady: assert property (fh_valid && !fh_ready |=> fh_valid && $stable({fh_data, fh_last, fh_port}))
		else $error("from-host beat changed while stalled");
	chk_fh_target: assert property (fh_valid |-> fh_port >= 3'h1 && fh_port <= 3'h4)
		else $error("host frame aimed at non-network port");
endmodule : spg_assertions
`default_nettype wire

// ### bench/switch_port_stp_state_gating_tb.sv
// Self-checking bench for the port state gating block
`timescale 1ns/1ns
`default_nettype none
module switch_port_stp_state_gating_tb;
	import spg_pkg::*;
	localparam int LIMIT = 20000;
	localparam logic [7:0] EXP_BITS [5] = '{8'h01, 8'h01, 8'h01, 8'h00, 8'h06};
	logic clk, rst_n, ing_valid, ing_ready, ing_last, ing_ovr;
	logic [SPG_DW-1:0] ing_data, egr_data, tag_data, hrx_data, htx_data, last_egr;
	logic [2:0] ing_src, ing_dst, egr_port, tag_port, learn_port, hrx_port, htx_port, last_hrx;
	logic egr_valid, egr_ready, egr_last, tag_valid, tag_ready, tag_last, learn_valid;
	logic awvalid, awready, wvalid, wready, bvalid, bready, arvalid, arready, rvalid, rready;
	logic [7:0] awaddr, araddr;
	logic [31:0] wdata, rdata, v;
	logic [1:0] bresp, rresp, r;
	logic hrx_valid, hrx_ready, hrx_last, htx_valid, htx_ready, htx_last, ovr_needed;
	logic [3:0] last_ep;
	logic [8:0] last_hd;
	logic [11:0] last_tag;
	int err_count = 0, num_checks = 0, cyc = 0, ing_n = 0, egr_n = 0, hrx_n = 0, tag_n = 0;
	int lrn_n = 0, e0, h0, t0, l0;

	spg_link_if lk_if();
	spg_switch_end u_spg_switch_end (.clk, .rst_n, .lk(lk_if), .ing_valid, .ing_ready, .ing_data,
		.ing_last, .ing_src, .ing_dst, .ing_ovr, .egr_valid, .egr_ready, .egr_data, .egr_last,
		.egr_port, .tag_valid, .tag_ready, .tag_data, .tag_last, .tag_port, .learn_valid,
		.learn_port);
	spg_host_end u_spg_host_end (.clk, .rst_n, .lk(lk_if), .awvalid, .awready, .awaddr, .wvalid,
		.wready, .wdata, .wstrb(4'hF), .bvalid, .bready, .bresp, .arvalid, .arready, .araddr,
		.rvalid, .rready, .rdata, .rresp, .hrx_valid, .hrx_ready, .hrx_data, .hrx_last, .hrx_port,
		.htx_valid, .htx_ready, .htx_data, .htx_last, .htx_port, .ovr_needed);
	spg_assertions u_chk (.clk, .rst_n, .reg_req(lk_if.reg_req), .reg_we(lk_if.reg_we),
		.reg_addr(lk_if.reg_addr), .reg_wdata(lk_if.reg_wdata), .reg_ack(lk_if.reg_ack),
		.reg_rdata(lk_if.reg_rdata), .th_valid(lk_if.th_valid), .th_ready(lk_if.th_ready),
		.th_data(lk_if.th_data), .th_last(lk_if.th_last), .th_port(lk_if.th_port),
		.fh_valid(lk_if.fh_valid), .fh_ready(lk_if.fh_ready), .fh_data(lk_if.fh_data),
		.fh_last(lk_if.fh_last), .fh_port(lk_if.fh_port));

	initial
	begin
		clk = 1'b0;
		forever #20 clk = ~clk;
	end

	task automatic test_done();
		if (err_count == 0 && num_checks > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask : test_done

	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		num_checks++;
		if (seen !== exp)
		begin
			err_count++;
			$display("Error at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask : chk

	// Beat counters; the timeout also lives here
	always @(posedge clk)
	begin
		cyc++;
		if (ing_valid && ing_ready)
			ing_n++;
		if (egr_valid && egr_ready)
		begin
			egr_n++;
			last_egr = egr_data;
			last_ep = {egr_last, egr_port};
		end
		if (hrx_valid && hrx_ready)
		begin
			hrx_n++;
			last_hrx = hrx_port;
			last_hd = {hrx_last, hrx_data};
		end
		if (tag_valid && tag_ready)
		begin
			tag_n++;
			last_tag = {tag_last, tag_port, tag_data};
		end
		if (learn_valid && learn_port == 3'h1)
			lrn_n++;
		if (cyc == LIMIT)
		begin
			err_count++;
			test_done();
		end
	end

	task automatic axi_wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] e);
		@(posedge clk);
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		awaddr <= a;
		wdata <= d;
		bready <= 1'b1;
		do
		begin
			@(posedge clk);
			if (awready)
				awvalid <= 1'b0;
			if (wready)
				wvalid <= 1'b0;
		end while (!bvalid);
		e = bresp;
		bready <= 1'b0;
	endtask : axi_wr

	task automatic axi_rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] e);
		@(posedge clk);
		arvalid <= 1'b1;
		araddr <= a;
		rready <= 1'b1;
		do
		begin
			@(posedge clk);
			if (arready)
				arvalid <= 1'b0;
		end while (!rvalid);
		d = rdata;
		e = rresp;
		rready <= 1'b0;
	endtask : axi_rd

	task automatic wait_idle();
		do axi_rd(SPG_HR_STATUS, v, r); while (v[SPG_STAT_BUSY_BIT]);
	endtask : wait_idle

	task automatic set_state(input logic [2:0] p, input logic [2:0] st);
		axi_wr(SPG_HR_STATE, {26'h0, 2'(p - 3'h1), 1'b0, st}, r);
		chk(r, SPG_RESP_OKAY);
		wait_idle();
	endtask : set_state

	// Device register byte lands in v[15:8]
	task automatic dev_rd(input logic [7:0] a);
		axi_wr(SPG_HR_READ, {24'h0, a}, r);
		wait_idle();
	endtask : dev_rd

	task automatic send(input logic [2:0] s, input logic [2:0] d, input logic o, input int n);
		@(posedge clk);
		for (int i = 0; i < n; i++)
		begin
			ing_valid <= 1'b1;
			ing_src <= s;
			ing_dst <= d;
			ing_ovr <= o;
			ing_data <= 8'(8'hA0 + i);
			ing_last <= (i == n - 1);
			do @(posedge clk); while (!ing_ready);
		end
		ing_valid <= 1'b0;
	endtask : send

	task automatic host_send(input logic [2:0] d);
		@(posedge clk);
		htx_valid <= 1'b1;
		htx_port <= d;
		htx_data <= 8'h5A;
		htx_last <= 1'b1;
		do @(posedge clk); while (!htx_ready);
		htx_valid <= 1'b0;
	endtask : host_send

	initial
	begin
		{rst_n, ing_valid, ing_last, ing_ovr, awvalid, wvalid, bready, arvalid, rready} = '0;
		{htx_valid, htx_last, ing_data, ing_src, ing_dst, awaddr, araddr, wdata} = '0;
		{htx_data, htx_port} = '0;
		{egr_ready, tag_ready, hrx_ready} = 3'h7;
		repeat (4) @(posedge clk);
		rst_n <= 1'b1;
		chk(ovr_needed, 1);
		axi_rd(SPG_HR_STATE, v, r);
		chk(v, 32'h924);
		for (int p = 0; p < 4; p++)
		begin
			dev_rd(SPG_CTL_OFF[p]);
			chk(v[15:8], 8'h06);
		end
		dev_rd(8'h13);
		chk(v[15:8], 8'h00);
		axi_wr(8'h10, 32'h0, r);
		chk(r, SPG_RESP_SLVERR);
		axi_rd(8'h10, v, r);
		chk(r, SPG_RESP_SLVERR);
		chk(v, 32'h0000_0000);
		for (int st = 0; st < 5; st++)
		begin
			set_state(3'h1, 3'(st));
			axi_rd(SPG_HR_STATE, v, r);
			chk(v[2:0], st);
			dev_rd(8'h12);
			chk(v[15:8], EXP_BITS[st]);
			e0 = egr_n;
			h0 = hrx_n;
			t0 = tag_n;
			l0 = lrn_n;
			send(3'h1, 3'h2, 1'b0, 2);
			send(3'h2, 3'h1, 1'b0, 1);
			send(3'h5, 3'h2, 1'b0, 1);
			hrx_ready <= 1'b0;
			send(3'h1, 3'h5, 1'b1, 1);
			send(3'h1, 3'h5, 1'b0, 1);
			repeat (6) @(posedge clk);
			hrx_ready <= 1'b1;
			host_send(3'h1);
			repeat (12) @(posedge clk);
			chk(egr_n - e0, st == 4 ? 4 : 1);
			chk(hrx_n - h0, (st != 0) + (st == 4));
			chk(lrn_n - l0, st >= 3 ? 3 : 0);
			chk(tag_n - t0, st >= 2);
		end
		chk(last_hrx, 3'h1);
		chk(last_hd, 9'h1A0);
		// Two host beats against a stalled network side: the second waits on the link
		t0 = tag_n;
		tag_ready <= 1'b0;
		host_send(3'h1);
		host_send(3'h1);
		repeat (4) @(posedge clk);
		chk(tag_n - t0, 0);
		tag_ready <= 1'b1;
		repeat (8) @(posedge clk);
		chk(tag_n - t0, 2);
		chk(last_tag, 12'h95A);
		axi_rd(SPG_HR_DROPS, v, r);
		chk(v, 1);
		set_state(3'h1, SPG_ST_FORWARDING);
		egr_ready <= 1'b0;
		e0 = egr_n;
		l0 = ing_n;
		fork
			send(3'h2, 3'h1, 1'b0, 8);
		join_none
		repeat (20) @(posedge clk);
		chk(ing_n - l0, 3);
		chk(ing_ready, 0);
		set_state(3'h1, SPG_ST_DISABLED);
		egr_ready <= 1'b1;
		wait fork;
		repeat (12) @(posedge clk);
		chk(egr_n - e0, 8);
		chk(last_egr, 8'hA7);
		chk(last_ep, 4'h9);
		send(3'h2, 3'h1, 1'b0, 1);
		repeat (12) @(posedge clk);
		chk(egr_n - e0, 8);
		for (int p = 2; p < 5; p++)
		begin
			set_state(3'(p), SPG_ST_DISABLED);
		end
		chk(ovr_needed, 0);
		test_done();
	end
endmodule : switch_port_stp_state_gating_tb
`default_nettype wire

// ### hw/spg_host_end.sv
// Processor end: AXI4-Lite controlled spanning tree state setter and frame filter
//
// The AXI4-Lite interface to the registers was chosen for this implementation.
`timescale 1ns/1ns
`default_nettype none
module spg_host_end
	import spg_pkg::*;
(
	input wire logic clk, // Core clock
	input wire logic rst_n, // Asynchronous reset
	spg_link_if.host lk, // Host port link
	input wire logic awvalid, // AXI write address valid
	output logic awready, // AXI write address ready
	input wire logic [7:0] awaddr, // AXI write address
	input wire logic wvalid, // AXI write data valid
	output logic wready, // AXI write data ready
	input wire logic [31:0] wdata, // AXI write data
	input wire logic [3:0] wstrb, // AXI byte enables, full words only
	output logic bvalid, // AXI write response valid
	input wire logic bready, // AXI write response ready
	output logic [1:0] bresp, // AXI write response
	input wire logic arvalid, // AXI read address valid
	output logic arready, // AXI read address ready
	input wire logic [7:0] araddr, // AXI read address
	output logic rvalid, // AXI read data valid
	input wire logic rready, // AXI read data ready
	output logic [31:0] rdata, // AXI read data
	output logic [1:0] rresp, // AXI read response
	output logic hrx_valid, // Frame beat for the processor
	input wire logic hrx_ready, // Processor accepts beat
	output logic [SPG_DW-1:0] hrx_data, // Received beat data
	output logic hrx_last, // Last beat of received frame
	output logic [2:0] hrx_port, // Port the frame came in on
	input wire logic htx_valid, // Processor frame beat to send
	output logic htx_ready, // Send path accepts beat
	input wire logic [SPG_DW-1:0] htx_data, // Beat data to send
	input wire logic htx_last, // Last beat of frame to send
	input wire logic [2:0] htx_port, // Target port for the tail tag
	output logic ovr_needed // Override entries must be present
);

	typedef struct packed {
		logic awr;
		logic bv;
		logic [1:0] br;
		logic arr;
		logic rv;
		logic [31:0] rd;
		logic [1:0] rr;
		logic req;
		logic we;
		logic [7:0] addr;
		logic [7:0] wd;
		logic [7:0] rdback;
		logic [3:0][2:0] st;
		logic [15:0] drops;
		logic hv;
		logic [SPG_DW-1:0] hd;
		logic hl;
		logic [2:0] hp;
		logic th_rdy;
		logic rx_act;
		logic rx_drop;
		logic fv;
		logic [SPG_DW-1:0] fd;
		logic fl;
		logic [2:0] fp;
		logic tx_rdy;
		logic tx_act;
		logic tx_drop;
		logic ovr;
	} spg_host_st_t;

	spg_host_st_t s_q;
	spg_host_st_t s_d;

	always_comb
	begin
		logic [1:0] p;
		logic drop;
		s_d = s_q;
		p = wdata[SPG_CMD_PORT_LSB +: 2];
		drop = 1'b0;

		// Write channel: address and data are taken together
		s_d.awr = awvalid && wvalid && !s_q.awr && !s_q.bv;
		if (s_q.bv && bready)
		begin
			s_d.bv = 1'b0;
		end
		if (s_q.awr)
		begin
			s_d.bv = 1'b1;
			s_d.br = SPG_RESP_OKAY;
			if (awaddr == SPG_HR_STATE)
			begin
				if (!s_q.req)
				begin
					s_d.st[p] = wdata[SPG_CMD_ST_LSB +: 3];
					s_d.req = 1'b1;
					s_d.we = 1'b1;
					s_d.addr = SPG_CTL_OFF[p];
					s_d.wd = spg_state_bits(wdata[SPG_CMD_ST_LSB +: 3]);
				end
			end
			else if (awaddr == SPG_HR_READ)
			begin
				if (!s_q.req)
				begin
					s_d.req = 1'b1;
					s_d.we = 1'b0;
					s_d.addr = wdata[7:0];
				end
			end
			else
			begin
				s_d.br = SPG_RESP_SLVERR;
			end
		end

		// Read channel
		s_d.arr = arvalid && !s_q.arr && !s_q.rv;
		if (s_q.rv && rready)
		begin
			s_d.rv = 1'b0;
		end
		if (s_q.arr)
		begin
			s_d.rv = 1'b1;
			s_d.rr = SPG_RESP_OKAY;
			s_d.rd = 32'h0000_0000;
			case (araddr)
				SPG_HR_STATE: s_d.rd = {20'h0_0000, s_q.st};
				SPG_HR_STATUS:
				begin
					s_d.rd[SPG_STAT_BUSY_BIT] = s_q.req;
					s_d.rd[SPG_STAT_RD_LSB +: 8] = s_q.rdback;
				end
				SPG_HR_DROPS: s_d.rd = {16'h0000, s_q.drops};
				default: s_d.rr = SPG_RESP_SLVERR;
			endcase
		end

		// Device register request held until its acknowledge
		if (s_q.req && lk.reg_ack)
		begin
			s_d.req = 1'b0;
			if (!s_q.we)
			begin
				s_d.rdback = lk.reg_rdata;
			end
		end

		// Frames from the switch; disabled-port frames are discarded whole
		if (s_q.hv && hrx_ready)
		begin
			s_d.hv = 1'b0;
		end
		if (lk.th_valid && s_q.th_rdy)
		begin
			drop = s_q.rx_act ? s_q.rx_drop
				: (spg_is_net(lk.th_port) && s_q.st[spg_pidx(lk.th_port)] == SPG_ST_DISABLED);
			if (!drop)
			begin
				s_d.hv = 1'b1;
				s_d.hd = lk.th_data;
				s_d.hl = lk.th_last;
				s_d.hp = lk.th_port;
			end
			if (drop && !s_q.rx_act)
			begin
				s_d.drops = s_q.drops + 16'h0001;
			end
			s_d.rx_act = !lk.th_last;
			s_d.rx_drop = drop;
		end
		s_d.th_rdy = !s_d.hv;

		// Frames to the switch, tail tag names the port
		drop = 1'b0;
		if (s_q.fv && lk.fh_ready)
		begin
			s_d.fv = 1'b0;
		end
		if (htx_valid && s_q.tx_rdy)
		begin
			drop = s_q.tx_act ? s_q.tx_drop
				: (!spg_is_net(htx_port) || s_q.st[spg_pidx(htx_port)] <= SPG_ST_BLOCKING);
			if (!drop)
			begin
				s_d.fv = 1'b1;
				s_d.fd = htx_data;
				s_d.fl = htx_last;
				s_d.fp = htx_port;
			end
			s_d.tx_act = !htx_last;
			s_d.tx_drop = drop;
		end
		s_d.tx_rdy = !s_d.fv;

		s_d.ovr = 1'b0;
		for (int i = 0; i < 4; i++)
		begin
			s_d.ovr = s_d.ovr || (s_d.st[i] != SPG_ST_DISABLED);
		end
	end

	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			s_q <= '0;
			s_q.st <= {4{SPG_ST_FORWARDING}};
			s_q.th_rdy <= 1'b1;
			s_q.tx_rdy <= 1'b1;
			s_q.ovr <= 1'b1;
		end
		else
		begin
			s_q <= s_d;
		end
	end

	assign awready = s_q.awr;
	assign wready = s_q.awr;
	assign bvalid = s_q.bv;
	assign bresp = s_q.br;
	assign arready = s_q.arr;
	assign rvalid = s_q.rv;
	assign rdata = s_q.rd;
	assign rresp = s_q.rr;
	assign hrx_valid = s_q.hv;
	assign hrx_data = s_q.hd;
	assign hrx_last = s_q.hl;
	assign hrx_port = s_q.hp;
	assign htx_ready = s_q.tx_rdy;
	assign ovr_needed = s_q.ovr;
	assign lk.reg_req = s_q.req;
	assign lk.reg_we = s_q.we;
	assign lk.reg_addr = s_q.addr;
	assign lk.reg_wdata = s_q.wd;
	assign lk.th_ready = s_q.th_rdy;
	assign lk.fh_valid = s_q.fv;
	assign lk.fh_data = s_q.fd;
	assign lk.fh_last = s_q.fl;
	assign lk.fh_port = s_q.fp;

endmodule : spg_host_end
`default_nettype wire

// ### hw/spg_link_if.sv
// Host port link between the switch end and the processor end
`timescale 1ns/1ns
`default_nettype none
interface spg_link_if;
	import spg_pkg::*;
	logic reg_req;
	logic reg_we;
	logic [7:0] reg_addr;
	logic [7:0] reg_wdata;
	logic reg_ack;
	logic [7:0] reg_rdata;
	logic th_valid;
	logic th_ready;
	logic [SPG_DW-1:0] th_data;
	logic th_last;
	logic [2:0] th_port;
	logic fh_valid;
	logic fh_ready;
	logic [SPG_DW-1:0] fh_data;
	logic fh_last;
	logic [2:0] fh_port;

	modport dev (
		input reg_req, reg_we, reg_addr, reg_wdata, th_ready,
		input fh_valid, fh_data, fh_last, fh_port,
		output reg_ack, reg_rdata, th_valid, th_data, th_last, th_port, fh_ready
	);
	modport host (
		output reg_req, reg_we, reg_addr, reg_wdata, th_ready,
		output fh_valid, fh_data, fh_last, fh_port,
		input reg_ack, reg_rdata, th_valid, th_data, th_last, th_port, fh_ready
	);
endinterface : spg_link_if
`default_nettype wire

// ### hw/spg_pkg.sv
// Shared constants, register map and helper functions for the port state gating block
package spg_pkg;

	localparam int SPG_DW = 8;
	localparam logic [2:0] SPG_HOST_PORT = 3'h5;

	// Per-port control registers, index 0 is port 1
	localparam logic [3:0][7:0] SPG_CTL_OFF = {8'h42, 8'h32, 8'h22, 8'h12};
	localparam int SPG_TX_EN_BIT = 2;
	localparam int SPG_RX_EN_BIT = 1;
	localparam int SPG_LRN_DIS_BIT = 0;
	localparam logic [7:0] SPG_CTL_RST = 8'h06;

	// Spanning tree state codes as software sees them
	localparam logic [2:0] SPG_ST_DISABLED = 3'h0;
	localparam logic [2:0] SPG_ST_BLOCKING = 3'h1;
	localparam logic [2:0] SPG_ST_LISTENING = 3'h2;
	localparam logic [2:0] SPG_ST_LEARNING = 3'h3;
	localparam logic [2:0] SPG_ST_FORWARDING = 3'h4;

	// Frame routes chosen at the first beat
	localparam logic [1:0] SPG_RT_DROP = 2'h0;
	localparam logic [1:0] SPG_RT_NET = 2'h1;
	localparam logic [1:0] SPG_RT_HOST = 2'h2;

	// Controller registers on AXI4-Lite
	localparam logic [7:0] SPG_HR_STATE = 8'h00;
	localparam logic [7:0] SPG_HR_STATUS = 8'h04;
	localparam logic [7:0] SPG_HR_READ = 8'h08;
	localparam logic [7:0] SPG_HR_DROPS = 8'h0C;
	localparam int SPG_CMD_ST_LSB = 0;
	localparam int SPG_CMD_PORT_LSB = 4;
	localparam int SPG_STAT_BUSY_BIT = 0;
	localparam int SPG_STAT_RD_LSB = 8;
	localparam logic [1:0] SPG_RESP_OKAY = 2'h0;
	localparam logic [1:0] SPG_RESP_SLVERR = 2'h2;

	function automatic logic spg_is_net(input logic [2:0] p);
		return (p >= 3'h1) && (p <= 3'h4);
	endfunction : spg_is_net

	function automatic logic [1:0] spg_pidx(input logic [2:0] p);
		logic [2:0] t;
		t = p - 3'h1;
		return t[1:0];
	endfunction : spg_pidx

	// Bit 2 is a hit flag, bits 1:0 the port index
	function automatic logic [2:0] spg_ctl_sel(input logic [7:0] a);
		logic [2:0] r;
		r = 3'h0;
		for (int i = 0; i < 4; i++)
		begin
			if (a == SPG_CTL_OFF[i])
			begin
				r = {1'b1, 2'(i)};
			end
		end
		return r;
	endfunction : spg_ctl_sel

	function automatic logic [7:0] spg_state_bits(input logic [2:0] st);
		logic [7:0] b;
		b = 8'h00;
		case (st)
			SPG_ST_FORWARDING:
			begin
				b[SPG_TX_EN_BIT] = 1'b1;
				b[SPG_RX_EN_BIT] = 1'b1;
			end
			SPG_ST_LEARNING:
			begin
				b = 8'h00;
			end
			default:
			begin
				b[SPG_LRN_DIS_BIT] = 1'b1;
			end
		endcase
		return b;
	endfunction : spg_state_bits

endpackage : spg_pkg

// ### hw/spg_switch_end.sv
// Switch end: per-port spanning tree gating of forwarding, reception and learning
// Summary of operation
// - Port 5 is host port, never gated
// - Ports 1-4 each own tx, rx, learn-disable bits
// - Five spanning tree states set by three bits
// - Disabled: no forward, no receive, no learning
// - Override-table hits still reach host when disabled
// - Processor drops frames from disabled ports
// - Processor never sends to disabled or blocking ports
// - Blocking: only override hits to processor, no learning
// - Processor programs override entries for protocol frames
// - Listening: only processor traffic, learning stays off
// - Learning: only processor traffic, addresses learned
// - Forwarding: normal traffic and learning
// - Processor may send tail-tagged frames to port
// - All processor traffic crosses the host port link
`timescale 1ns/1ns
`default_nettype none
module spg_switch_end
	import spg_pkg::*;
(
	input wire logic clk, // Core clock
	input wire logic rst_n, // Asynchronous reset
	spg_link_if.dev lk, // Host port link
	input wire logic ing_valid, // Ingress beat valid
	output logic ing_ready, // Ingress buffer has room
	input wire logic [SPG_DW-1:0] ing_data, // Ingress beat data
	input wire logic ing_last, // Last beat of frame
	input wire logic [2:0] ing_src, // Receiving port
	input wire logic [2:0] ing_dst, // Looked-up destination port
	input wire logic ing_ovr, // Static entry with override hit
	output logic egr_valid, // Switched beat to a network port
	input wire logic egr_ready, // Egress accepts beat
	output logic [SPG_DW-1:0] egr_data, // Switched beat data
	output logic egr_last, // Last beat of switched frame
	output logic [2:0] egr_port, // Egress network port
	output logic tag_valid, // Host-sent beat to a network port
	input wire logic tag_ready, // Network side accepts host beat
	output logic [SPG_DW-1:0] tag_data, // Host-sent beat data
	output logic tag_last, // Last beat of host-sent frame
	output logic [2:0] tag_port, // Port chosen by tail tag
	output logic learn_valid, // Learn source address now
	output logic [2:0] learn_port // Port the address was seen on
);

	typedef struct packed {
		logic ovr;
		logic [2:0] dst;
		logic [2:0] src;
		logic last;
		logic [SPG_DW-1:0] data;
	} spg_ent_t;

	typedef struct packed {
		logic [3:0][7:0] ctl;
		spg_ent_t [1:0] mem;
		logic wp;
		logic rp;
		logic [1:0] cnt;
		logic in_rdy;
		logic fr_act;
		logic [1:0] route;
		logic egr_v;
		logic [SPG_DW-1:0] egr_d;
		logic egr_l;
		logic [2:0] egr_p;
		logic th_v;
		logic [SPG_DW-1:0] th_d;
		logic th_l;
		logic [2:0] th_p;
		logic tag_v;
		logic [SPG_DW-1:0] tag_d;
		logic tag_l;
		logic [2:0] tag_p;
		logic fh_rdy;
		logic lrn_v;
		logic [2:0] lrn_p;
		logic ack;
		logic [7:0] rdata;
	} spg_dev_st_t;

	spg_dev_st_t s_q;
	spg_dev_st_t s_d;

	always_comb
	begin
		spg_ent_t head;
		logic [2:0] sel;
		logic push;
		logic pop;
		logic rx_ok;
		logic tx_ok;
		logic [1:0] rt;
		logic [7:0] sc;
		logic [7:0] dc;
		s_d = s_q;
		head = s_q.mem[s_q.rp];
		sel = 3'h0;
		push = 1'b0;
		pop = 1'b0;
		rx_ok = 1'b0;
		tx_ok = 1'b0;
		rt = SPG_RT_DROP;
		sc = s_q.ctl[spg_pidx(head.src)];
		dc = s_q.ctl[spg_pidx(head.dst)];
		s_d.lrn_v = 1'b0;
		s_d.ack = 1'b0;

		// Control register port, answered one cycle after the request
		if (lk.reg_req && !s_q.ack)
		begin
			sel = spg_ctl_sel(lk.reg_addr);
			s_d.ack = 1'b1;
			s_d.rdata = 8'h00;
			if (sel[2])
			begin
				if (lk.reg_we)
				begin
					s_d.ctl[sel[1:0]] = lk.reg_wdata;
				end
				s_d.rdata = lk.reg_we ? lk.reg_wdata : s_q.ctl[sel[1:0]];
			end
		end

		// Host-sent frames go out on the tail-tagged port in any state
		if (s_q.tag_v && tag_ready)
		begin
			s_d.tag_v = 1'b0;
		end
		if (lk.fh_valid && s_q.fh_rdy)
		begin
			s_d.tag_v = 1'b1;
			s_d.tag_d = lk.fh_data;
			s_d.tag_l = lk.fh_last;
			s_d.tag_p = lk.fh_port;
		end
		s_d.fh_rdy = !s_d.tag_v;

		// Output slots free up on their handshakes
		if (s_q.egr_v && egr_ready)
		begin
			s_d.egr_v = 1'b0;
		end
		if (s_q.th_v && lk.th_ready)
		begin
			s_d.th_v = 1'b0;
		end

		// Ingress buffer fill
		if (ing_valid && s_q.in_rdy)
		begin
			push = 1'b1;
			s_d.mem[s_q.wp] = {ing_ovr, ing_dst, ing_src, ing_last, ing_data};
			s_d.wp = !s_q.wp;
		end

		// Route chosen from the bits in force at the first beat
		rx_ok = !spg_is_net(head.src) || sc[SPG_RX_EN_BIT];
		tx_ok = !spg_is_net(head.dst) || dc[SPG_TX_EN_BIT];
		if (s_q.fr_act)
		begin
			rt = s_q.route;
		end
		else if (head.dst == SPG_HOST_PORT)
		begin
			rt = (head.ovr || rx_ok) ? SPG_RT_HOST : SPG_RT_DROP;
		end
		else if (spg_is_net(head.dst) && rx_ok && tx_ok)
		begin
			rt = SPG_RT_NET;
		end
		else
		begin
			rt = SPG_RT_DROP;
		end

		// Buffer drain, stalls while the chosen slot is occupied
		if (s_q.cnt != 2'h0)
		begin
			case (rt)
				SPG_RT_NET:
				begin
					pop = !s_d.egr_v;
					if (pop)
					begin
						s_d.egr_v = 1'b1;
						s_d.egr_d = head.data;
						s_d.egr_l = head.last;
						s_d.egr_p = head.dst;
					end
				end
				SPG_RT_HOST:
				begin
					pop = !s_d.th_v;
					if (pop)
					begin
						s_d.th_v = 1'b1;
						s_d.th_d = head.data;
						s_d.th_l = head.last;
						s_d.th_p = head.src;
					end
				end
				default:
				begin
					pop = 1'b1;
				end
			endcase
		end
		if (pop)
		begin
			s_d.rp = !s_q.rp;
			s_d.fr_act = !head.last;
			s_d.route = rt;
			if (!s_q.fr_act && spg_is_net(head.src) && !sc[SPG_LRN_DIS_BIT])
			begin
				s_d.lrn_v = 1'b1;
				s_d.lrn_p = head.src;
			end
		end
		s_d.cnt = 2'(s_q.cnt + {1'b0, push} - {1'b0, pop});
		s_d.in_rdy = (s_d.cnt != 2'h2);
	end

	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			s_q <= '0;
			s_q.ctl <= {4{SPG_CTL_RST}};
			s_q.in_rdy <= 1'b1;
			s_q.fh_rdy <= 1'b1;
		end
		else
		begin
			s_q <= s_d;
		end
	end

	assign ing_ready = s_q.in_rdy;
	assign egr_valid = s_q.egr_v;
	assign egr_data = s_q.egr_d;
	assign egr_last = s_q.egr_l;
	assign egr_port = s_q.egr_p;
	assign tag_valid = s_q.tag_v;
	assign tag_data = s_q.tag_d;
	assign tag_last = s_q.tag_l;
	assign tag_port = s_q.tag_p;
	assign learn_valid = s_q.lrn_v;
	assign learn_port = s_q.lrn_p;
	assign lk.reg_ack = s_q.ack;
	assign lk.reg_rdata = s_q.rdata;
	assign lk.th_valid = s_q.th_v;
	assign lk.th_data = s_q.th_d;
	assign lk.th_last = s_q.th_l;
	assign lk.th_port = s_q.th_p;
	assign lk.fh_ready = s_q.fh_rdy;

endmodule : spg_switch_end
`default_nettype wire
